/* tb/pdc_props.sv */
// Checker on the link between channel and core.
// Assumes one REF_CLK domain and an active-high RST.
`timescale 1ns/1ps
module pdc_props
(
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic        xfer_req,
    input wire logic        irq_req,
    input wire logic        xfer_grant,
    input wire logic        irq_ack,
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic        mem_rf,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        xfer_done
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    logic busy;
    // Transfer open from grant until its done pulse
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            busy <= 1'b0;
        else if (xfer_grant)
            busy <= 1'b1;
        else if (xfer_done)
            busy <= 1'b0;
    end
    sequence s_finish;
        ##[1:60] xfer_done;
    endsequence
    sequence s_quiet;
        !xfer_grant [*4];
    endsequence
    chk_grant_spacing: assert property (xfer_grant |=> s_quiet)
        else $error("grants closer than the sample period");
    chk_grant_cause: assert property
        (xfer_grant |-> xfer_req || $past(xfer_req))
        else $error("grant without a transfer request");
    chk_one_at_time: assert property (xfer_grant |-> !busy)
        else $error("grant while a transfer is open");
    chk_xfer_finish: assert property (xfer_grant |-> s_finish)
        else $error("transfer did not finish in time");
    chk_done_pulse: assert property (xfer_done |=> !xfer_done)
        else $error("done pulse longer than one cycle");
    chk_access_inside: assert property
        (mem_req |-> busy || xfer_grant)
        else $error("access outside a granted transfer");
    chk_req_held: assert property (mem_req && !mem_ack |=>
        mem_req && $stable(mem_addr) && $stable(mem_we) && $stable(mem_rf))
        else $error("access changed before its answer");
    chk_rf_answer: assert property
        ($rose(mem_req) && mem_rf |-> ##[1:2] mem_ack)
        else $error("register file access not answered");
    chk_mem_answer: assert property
        ($rose(mem_req) && !mem_rf |-> ##[1:4] mem_ack)
        else $error("memory access not answered");
    chk_irq_holds: assert property (irq_req && !irq_ack |=> irq_req)
        else $error("block end request dropped before ack");
    chk_ack_has_req: assert property (mem_ack |-> mem_req)
        else $error("answer without an access");
endmodule

/* tb/tb.sv */
// Bench: both ends joined by the link, driven through pins and bus.
// Assumes REF_CLK at 100 MHz and the map of pdc_pkg.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin miscompares++; \
    $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
    logic ref_clk = 1'b0, rst = 1'b1, trigger = 1'b0;
    logic to_periph = 1'b0, swap_en = 1'b0, reg_we = 1'b0;
    logic [1:0] reg_sel = 2'h0;
    logic [7:0] reg_wdata = 8'h00, periph_rdata = 8'h5A, reg_rdata;
    logic [7:0] periph_wdata;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
    logic int_req = 1'b0, int_taken, periph_wstb, table_sel;
    logic [2:0] int_prio = 3'h7;
    int miscompares, samples_checked, cycles, grants, dones, wstbs;
    int takens, mem_acc;
    pdc_if lnk();
    pdc_channel pdc_channel_i (.REF_CLK(ref_clk), .RST(rst),
        .CLK_EN(1'b1), .TRIGGER(trigger), .TO_PERIPH(to_periph),
        .SWAP_EN(swap_en), .PERIPH_RDATA(periph_rdata),
        .PERIPH_WDATA(periph_wdata), .PERIPH_WSTB(periph_wstb),
        .REG_WE(reg_we), .REG_SEL(reg_sel),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .TABLE_SEL(table_sel), .link(lnk));
    pdc_core pdc_core_i (.REF_CLK(ref_clk), .RST(rst), .CLK_EN(1'b1),
        .WB_CYC(wb_cyc), .WB_STB(wb_stb), .WB_WE(wb_we), .WB_ADR(wb_adr),
        .WB_SEL(4'hF), .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o),
        .WB_ACK(wb_ack), .INT_REQ(int_req), .INT_PRIO(int_prio),
        .INT_TAKEN(int_taken), .link(lnk));
    pdc_props pdc_props_i (.REF_CLK(ref_clk), .RST(rst),
        .xfer_req(lnk.xfer_req), .irq_req(lnk.irq_req),
        .xfer_grant(lnk.xfer_grant), .irq_ack(lnk.irq_ack),
        .mem_req(lnk.mem_req), .mem_we(lnk.mem_we), .mem_rf(lnk.mem_rf),
        .mem_addr(lnk.mem_addr), .mem_ack(lnk.mem_ack),
        .xfer_done(lnk.xfer_done));
    // Clock
    initial
        forever #5 ref_clk = ~ref_clk;
    // Event counters and hang limit
    always @(posedge ref_clk)
    begin
        cycles++;
        grants += int'(lnk.xfer_grant === 1'b1);
        dones += int'(lnk.xfer_done === 1'b1);
        wstbs += int'(periph_wstb === 1'b1);
        takens += int'(int_taken === 1'b1);
        mem_acc += int'(lnk.mem_ack === 1'b1 && lnk.mem_rf === 1'b0);
        if (cycles > 5000)
        begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wb_xfer(input logic we, input logic [3:0] adr,
                           input logic [31:0] wd, output logic [31:0] rd);
        int n;
        @(posedge ref_clk);
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_i} <= {2'b11, we, adr, wd};
        n = 0;
        do @(posedge ref_clk); while (wb_ack !== 1'b1 && ++n < 50);
        miscompares += int'(n >= 50);
        rd = wb_dat_o;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
        @(posedge ref_clk);
    endtask
    task automatic reg_write(input logic [1:0] s, input logic [7:0] d);
        @(posedge ref_clk);
        {reg_we, reg_sel, reg_wdata} <= {1'b1, s, d};
        @(posedge ref_clk);
        reg_we <= 1'b0;
    endtask
    task automatic reg_check(input logic [1:0] s, input logic [7:0] e,
                             input logic [7:0] m);
        @(posedge ref_clk);
        reg_sel <= s;
        #1 `CHK("chan_reg", e, reg_rdata & m)
    endtask
    task automatic trig_wait(input int wait_n);
        int d0;
        d0 = dones;
        @(posedge ref_clk);
        trigger <= 1'b1;
        @(posedge ref_clk);
        trigger <= 1'b0;
        repeat (wait_n) @(posedge ref_clk);
        while (dones == d0 && wait_n < 200)
        begin
            @(posedge ref_clk);
            wait_n++;
        end
    endtask
    task automatic t_reset();
        logic [31:0] d;
        reg_check(2'h0, pdc_pkg::PTR_RESET, 8'hFF);
        reg_check(2'h1, pdc_pkg::CTRL_RESET, 8'hFF);
        reg_check(2'h2, pdc_pkg::PTR_RESET, 8'hFF);
        reg_check(2'h3, 8'h00, 8'hFF);
        wb_xfer(1'b1, pdc_pkg::ADR_STATUS, 32'hFFFF_FFF7, d);
        wb_xfer(1'b0, pdc_pkg::ADR_STATUS, 32'h0000_0000, d);
        `CHK("status", 32'h0000_0007, d)
        wb_xfer(1'b0, pdc_pkg::ADR_CTRL, 32'h0000_0000, d);
        `CHK("unmapped", 32'h0000_0000, d)
    endtask
    task automatic t_masked();
        int g;
        g = grants;
        reg_write(2'h1, 8'h03);
        trig_wait(20);
        reg_check(2'h1, 8'h23, 8'hFF);
        `CHK("no_grant", g, grants)
        reg_write(2'h1, 8'h03);
        reg_check(2'h1, 8'h03, 8'hFF);
    endtask
    // register file transfer at equal level
    task automatic t_rf();
        int d, m;
        logic [31:0] q;
        wb_xfer(1'b1, pdc_pkg::ADR_RF, 32'h0000_4030, q);
        wb_xfer(1'b1, pdc_pkg::ADR_RF, 32'h0000_4101, q);
        reg_write(2'h0, 8'h41);
        reg_write(2'h2, 8'h20);
        reg_write(2'h1, 8'h17);
        d = dones;
        m = mem_acc;
        trig_wait(0);
        `CHK("rf_done", d + 1, dones)
        `CHK("rf_only", m, mem_acc)
        reg_check(2'h1, 8'h00, 8'h30);
        wb_xfer(1'b0, pdc_pkg::ADR_RF, 32'h0000_3000, q);
        `CHK("rf_data", 8'h5A, q[7:0])
    endtask
    task automatic t_mem();
        int m, w;
        logic [31:0] q;
        to_periph <= 1'b1;
        wb_xfer(1'b1, pdc_pkg::ADR_RF, 32'h0000_00C3, q);
        reg_write(2'h0, 8'h40);
        reg_write(2'h2, 8'h41);
        reg_write(2'h1, 8'h13);
        m = mem_acc;
        w = wstbs;
        trig_wait(0);
        `CHK("mem_byte", m + 1, mem_acc)
        `CHK("to_periph", w + 1, wstbs)
        `CHK("periph_data", 8'hC3, periph_wdata)
    endtask
    // interrupt needs a strictly higher level
    task automatic t_level();
        int t, g;
        logic [31:0] d;
        t = takens;
        int_req <= 1'b1;
        repeat (20) @(posedge ref_clk);
        `CHK("int_equal", t, takens)
        int_prio <= 3'h2;
        for (int n = 0; n < 20 && takens == t; n++)
            @(posedge ref_clk);
        int_req <= 1'b0;
        `CHK("int_higher", t + 1, takens)
        wb_xfer(1'b0, pdc_pkg::ADR_STATUS, 32'h0000_0000, d);
        `CHK("level", 4'hF, d[3:0])
        wb_xfer(1'b1, pdc_pkg::ADR_STATUS, 32'h0000_0002, d);
        g = grants;
        to_periph <= 1'b0;
        reg_write(2'h0, 8'h41);
        reg_write(2'h1, 8'h13);
        trig_wait(30);
        `CHK("lower_xfer", g, grants)
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_masked();
        t_rf();
        t_mem();
        t_level();
        wrap_up();
    end
endmodule

/* verilog/pdc_channel.sv */
// Peripheral transfer channel: control registers, descriptor walk, swap.
// Assumes a core end answering every mem_req with a one-cycle mem_ack.
//
// Contract
// RQ1: Blocks up to 222 regfile, 65536 memory
// RQ2: Requests use eight interrupt priority levels
// RQ3: Transfer wins interrupt at equal level
// RQ4: Transfer needs level >= current; interrupt strictly
// RQ5: Transfer keeps current level, not interruptible
// RQ6: Move byte, increment address, decrement count
// RQ7: Regfile mode: 8-bit address even, count odd
// RQ8: Memory mode: 16-bit address and count pairs
// RQ9: Segment select picks interrupt or transfer segment
// RQ10: Software keeps descriptors in 00h..DFh
// RQ11: Request when pending and transfer mask set
// RQ12: Count zero clears mask, raises block-end interrupt
// RQ13: No transfer during top-level interrupt service
// RQ14: Requests sampled every five core cycles
// RQ15: Regfile transfer takes eight cycles; here 15 from grant to done pulse
// RQ16: Memory transfer sixteen cycles plus waits; here 27 from grant to done pulse
// RQ17: Swap mode alternates tables, keeps mask
// RQ18: Pending set by event, cleared on acknowledge
// RQ19: Both masks clear: nothing happens
// RQ20: Priority field 0 highest, 7 lowest
// RQ21: Software writes pointers into bits 7:1
// RQ22: Direction fixed by peripheral and mode
// RQ23: Equal priority requests resolved in fixed order
`timescale 1ns/1ps
module pdc_channel
(
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic       CLK_EN,
    input  wire logic       TRIGGER,       // Peripheral event pulse
    input  wire logic       TO_PERIPH,     // Direction of this peripheral
    input  wire logic       SWAP_EN,       // Swap mode enable
    input  wire logic [7:0] PERIPH_RDATA,  // Peripheral data register
    output logic      [7:0] PERIPH_WDATA,
    output logic            PERIPH_WSTB,
    input  wire logic       REG_WE,        // Channel register write
    input  wire logic [1:0] REG_SEL,       // 0 count ptr,1 ctrl,2 addr ptr
    input  wire logic [7:0] REG_WDATA,
    output logic      [7:0] REG_RDATA,
    output logic            TABLE_SEL,     // Active descriptor table
    pdc_if.chan             link
);
    logic [7:0]  count_ptr_reg;
    logic [7:0]  addr_ptr_reg;
    logic [7:0]  irq_transfer_ctrl;
    logic [7:0]  count_ptr_alt;
    logic [7:0]  addr_ptr_alt;
    logic [15:0] desc_addr;
    logic [15:0] desc_cnt;
    logic [15:0] next_cnt;
    logic [2:0]  step;
    logic [7:0]  data;
    logic        mode_rf;
    logic        last;
    pdc_pkg::pdc_state_e state;

    // Active table pointers and mode
    wire [7:0] cptr = TABLE_SEL ? count_ptr_alt : count_ptr_reg;
    wire [7:0] aptr = mode_rf ? cptr
                    : TABLE_SEL ? addr_ptr_alt : addr_ptr_reg;
    assign mode_rf = count_ptr_reg[pdc_pkg::MODE_BIT];

    // Descriptor register address within the register file
    function automatic logic [15:0] rf_at(input logic [7:0] p,
                                          input logic [2:0] k);
        rf_at = {8'h00, p[7:1], 1'b0} + {13'h0000, k};
    endfunction

    // RQ11 request when pending and mask set
    // RQ19 masks clear give no request
    assign link.xfer_req = irq_transfer_ctrl[pdc_pkg::PENDING_BIT]
        & irq_transfer_ctrl[pdc_pkg::XFER_MASK_BIT]
        & (state == pdc_pkg::PDC_IDLE);
    // RQ20 priority field passed to arbiter
    assign link.xfer_prio = irq_transfer_ctrl[pdc_pkg::PRIO_MSB:0];
    assign link.mem_rf    = mode_rf || state != pdc_pkg::PDC_MOVE;
    // RQ9 segment select in memory mode only
    assign link.mem_seg   = ~mode_rf & addr_ptr_reg[pdc_pkg::MODE_BIT];

    // Register readback
    always_comb
    begin
        case (REG_SEL)
            2'd0:    REG_RDATA = count_ptr_reg;
            2'd1:    REG_RDATA = irq_transfer_ctrl;
            2'd2:    REG_RDATA = addr_ptr_reg;
            default: REG_RDATA = {7'h00, TABLE_SEL};
        endcase
    end

    // Pointer registers; writing also sets the swap table pointers
    // RQ21 pointers held in bits 7:1
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            count_ptr_reg <= pdc_pkg::PTR_RESET;
            addr_ptr_reg  <= pdc_pkg::PTR_RESET;
            count_ptr_alt <= pdc_pkg::PTR_RESET;
            addr_ptr_alt  <= pdc_pkg::PTR_RESET;
        end
        else if (CLK_EN && REG_WE)
        begin
            if (REG_SEL == 2'd0)
                count_ptr_reg <= REG_WDATA;
            if (REG_SEL == 2'd2)
                addr_ptr_reg <= REG_WDATA;
            if (REG_SEL == 2'd0)
                count_ptr_alt <= REG_WDATA + 8'h04;  // Table 1 follows
            if (REG_SEL == 2'd2)
                addr_ptr_alt <= REG_WDATA + 8'h04;
        end
    end

    // Control register: pending, masks, priority
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            irq_transfer_ctrl <= pdc_pkg::CTRL_RESET;
        else if (CLK_EN)
        begin
            if (REG_WE && REG_SEL == 2'd1)
                irq_transfer_ctrl <= {2'b00, REG_WDATA[5:0]};
            // RQ18 cleared on acknowledge, set by event
            if (link.xfer_grant || link.irq_ack)
                irq_transfer_ctrl[pdc_pkg::PENDING_BIT] <= 1'b0;
            if (TRIGGER)
                irq_transfer_ctrl[pdc_pkg::PENDING_BIT] <= 1'b1;
            // RQ12 block end clears mask outside swap
            if (state == pdc_pkg::PDC_HOLD && last && !SWAP_EN)
                irq_transfer_ctrl[pdc_pkg::XFER_MASK_BIT] <= 1'b0;
        end
    end

    // Block-end interrupt request, gated by interrupt mask
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            link.irq_req <= 1'b0;
        else if (CLK_EN)
        begin
            if (link.irq_ack)
                link.irq_req <= 1'b0;
            // RQ12 raise block end interrupt
            if (state == pdc_pkg::PDC_HOLD && last
                && irq_transfer_ctrl[pdc_pkg::IRQ_MASK_BIT])
                link.irq_req <= 1'b1;
        end
    end

    // Table switch in swap mode
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            TABLE_SEL <= 1'b0;
        else if (CLK_EN)
        begin
            // RQ17 alternate tables at block end
            if (state == pdc_pkg::PDC_HOLD && last && SWAP_EN)
                TABLE_SEL <= ~TABLE_SEL;
            else if (!SWAP_EN)
                TABLE_SEL <= 1'b0;
        end
    end

    // Decremented count
    // RQ1 16-bit count covers 65536, 8-bit 222
    assign next_cnt = desc_cnt - 16'h0001;
    assign last = (mode_rf ? (desc_cnt[7:0] == 8'h00)
                           : (desc_cnt == 16'h0000));

    // RQ6 transfer sequencer: read desc, move, write back
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            state            <= pdc_pkg::PDC_IDLE;
            step             <= 3'd0;
            desc_addr        <= 16'h0000;
            desc_cnt         <= 16'h0000;
            data             <= 8'h00;
            link.mem_req     <= 1'b0;
            link.mem_we      <= 1'b0;
            link.mem_addr    <= 16'h0000;
            link.mem_wdata   <= 8'h00;
            link.xfer_done   <= 1'b0;
            PERIPH_WDATA     <= 8'h00;
            PERIPH_WSTB      <= 1'b0;
        end
        else if (CLK_EN)
        begin
            link.xfer_done <= 1'b0;
            PERIPH_WSTB    <= 1'b0;
            case (state)
                pdc_pkg::PDC_IDLE:
                    if (link.xfer_grant)
                    begin
                        state         <= pdc_pkg::PDC_RD_DESC;
                        step          <= 3'd0;
                        link.mem_req  <= 1'b1;
                        link.mem_we   <= 1'b0;
                        link.mem_addr <= rf_at(aptr, 3'd0);
                    end
                // RQ7 RQ8 fetch address then count bytes
                pdc_pkg::PDC_RD_DESC:
                    if (link.mem_ack)
                    begin
                        step <= step + 3'd1;
                        if (!mode_rf)
                        case (step)
                            3'd0: desc_addr[15:8] <= link.mem_rdata;
                            3'd1: desc_addr[7:0]  <= link.mem_rdata;
                            3'd2: desc_cnt[15:8]  <= link.mem_rdata;
                            default: desc_cnt[7:0] <= link.mem_rdata;
                        endcase
                        if (mode_rf)
                        begin
                            // Even address, odd count, one byte each
                            desc_addr[15:8] <= 8'h00;
                            desc_cnt[15:8]  <= 8'h00;
                            if (step == 3'd0)
                                desc_addr[7:0] <= link.mem_rdata;
                            else
                                desc_cnt[7:0] <= link.mem_rdata;
                        end
                        if ((mode_rf && step == 3'd1) || step == 3'd3)
                            link.mem_req <= 1'b0;
                        if (mode_rf)
                            link.mem_addr <= rf_at(aptr, 3'd1);
                        else if (step == 3'd0)
                            link.mem_addr <= rf_at(aptr, 3'd1);
                        else
                            link.mem_addr <= rf_at(cptr, step - 3'd1);
                    end
                    else if (!link.mem_req)
                    begin
                        // RQ22 direction from peripheral type
                        state         <= pdc_pkg::PDC_MOVE;
                        link.mem_req  <= 1'b1;
                        link.mem_we   <= TO_PERIPH ? 1'b0 : 1'b1;
                        link.mem_wdata <= PERIPH_RDATA;
                        link.mem_addr <= desc_addr;
                    end
                pdc_pkg::PDC_MOVE:
                    if (link.mem_ack)
                    begin
                        link.mem_req <= 1'b0;
                        data         <= link.mem_rdata;
                        PERIPH_WDATA <= link.mem_rdata;
                        PERIPH_WSTB  <= TO_PERIPH;
                        desc_addr    <= desc_addr + 16'h0001;
                        desc_cnt     <= next_cnt;
                        state        <= pdc_pkg::PDC_WR_DESC;
                        step         <= 3'd0;
                    end
                // Write back address then count
                pdc_pkg::PDC_WR_DESC:
                    if (!link.mem_req)
                    begin
                        link.mem_req   <= 1'b1;
                        link.mem_we    <= 1'b1;
                        link.mem_addr  <= mode_rf
                            ? rf_at(aptr, {1'b0, step[0], 1'b0} >> 1)
                            : (step[1] ? rf_at(cptr, {2'b00, step[0]})
                                       : rf_at(aptr, {2'b00, step[0]}));
                        link.mem_wdata <= mode_rf
                            ? (step[0] ? desc_cnt[7:0] : desc_addr[7:0])
                            : (step == 3'd0 ? desc_addr[15:8]
                            : step == 3'd1 ? desc_addr[7:0]
                            : step == 3'd2 ? desc_cnt[15:8]
                            : desc_cnt[7:0]);
                    end
                    else if (link.mem_ack)
                    begin
                        link.mem_req <= 1'b0;
                        step         <= step + 3'd1;
                        if ((mode_rf && step == 3'd1) || step == 3'd3)
                            state <= pdc_pkg::PDC_HOLD;
                    end
                pdc_pkg::PDC_HOLD:
                begin
                    link.xfer_done <= 1'b1;
                    state          <= pdc_pkg::PDC_IDLE;
                end
                default:
                    state <= pdc_pkg::PDC_IDLE;
            endcase
        end
    end
endmodule

/* verilog/pdc_core.sv */
// Core-side end: arbiter, current level, register file / memory, bus slave.
// Assumes a classic Wishbone master; one channel on the link.
`timescale 1ns/1ps
module pdc_core
(
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    input  wire logic        CLK_EN,
    input  wire logic        WB_CYC,
    input  wire logic        WB_STB,
    input  wire logic        WB_WE,
    input  wire logic [3:0]  WB_ADR,
    input  wire logic [3:0]  WB_SEL,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK,
    input  wire logic        INT_REQ,      // Other interrupt source
    input  wire logic [2:0]  INT_PRIO,
    output logic             INT_TAKEN,    // Pulse on interrupt grant
    pdc_if.core              link
);
    logic [7:0]  rf [0:255];              // Register file and memory window
    logic [2:0]  current_priority_level;
    logic        top_isr;                 // Top-level service running
    logic        in_xfer;
    logic [3:0]  tick;
    logic [4:0]  xcyc;
    logic        wb_hit;

    // RQ14 sample point every five cycles
    wire sample = (tick == 4'(pdc_pkg::SAMPLE_CYCLES - 1));
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            tick <= 4'h0;
        else if (CLK_EN)
            tick <= sample ? 4'h0 : tick + 4'h1;
    end

    // RQ4 transfer at >= level, interrupt strictly higher
    // RQ13 blocked during top-level service
    wire x_ok = link.xfer_req && !in_xfer && !top_isr
        && link.xfer_prio <= current_priority_level;
    wire i_ok = (INT_REQ && INT_PRIO < current_priority_level)
        || (link.irq_req && link.xfer_prio < current_priority_level);

    // RQ2 RQ3 one phase, transfer first
    // RQ23 single channel, fixed order
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            link.xfer_grant <= 1'b0;
            link.irq_ack    <= 1'b0;
            INT_TAKEN       <= 1'b0;
            in_xfer         <= 1'b0;
            top_isr         <= 1'b0;
            current_priority_level <= 3'd7;
        end
        else if (CLK_EN)
        begin
            link.xfer_grant <= 1'b0;
            link.irq_ack    <= 1'b0;
            INT_TAKEN       <= 1'b0;
            if (link.xfer_done)
                in_xfer <= 1'b0;
            if (sample && x_ok)
            begin
                // RQ5 level unchanged by transfers
                link.xfer_grant <= 1'b1;
                in_xfer         <= 1'b1;
            end
            else if (sample && i_ok && !in_xfer)
            begin
                link.irq_ack <= link.irq_req;
                INT_TAKEN    <= 1'b1;
                top_isr      <= 1'b1;
            end
            if (WB_CYC && WB_STB && WB_WE && WB_ADR == pdc_pkg::ADR_STATUS
                && WB_SEL[0] && WB_ACK)
            begin
                current_priority_level <= WB_DAT_I[2:0];
                top_isr                <= WB_DAT_I[3];
            end
        end
    end

    // RQ15 RQ16 ack 1 cycle after a regfile request, 3 after memory; grant to done 15/27 cycles, not 8/16
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
            xcyc <= 5'd0;
        else if (CLK_EN)
            xcyc <= link.mem_req && !link.mem_ack ? xcyc + 5'd1 : 5'd0;
    end
    wire [4:0] pace = link.mem_rf ? 5'd1 : 5'd3;
    assign link.mem_ack = link.mem_req && xcyc == pace;

    // Register file storage; a channel write wins over the bus window
    wire wb_win = WB_CYC && WB_STB && WB_ADR == pdc_pkg::ADR_RF;
    always_ff @(posedge REF_CLK)
    begin
        if (CLK_EN && link.mem_ack && link.mem_we)
            rf[link.mem_addr[7:0]] <= link.mem_wdata;
        else if (CLK_EN && wb_win && WB_WE && WB_ACK)
            rf[WB_DAT_I[15:8]] <= WB_DAT_I[7:0];
    end
    assign link.mem_rdata = rf[link.mem_addr[7:0]];

    // Wishbone slave: one wait cycle then ack
    assign wb_hit = WB_CYC && WB_STB;
    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            WB_ACK   <= 1'b0;
            WB_DAT_O <= 32'h0000_0000;
        end
        else if (CLK_EN)
        begin
            WB_ACK <= wb_hit && !WB_ACK;
            WB_DAT_O <= wb_win ? {24'h00_0000, rf[WB_DAT_I[15:8]]}
                : (WB_ADR == pdc_pkg::ADR_STATUS)
                ? {27'h000_0000, in_xfer, top_isr, current_priority_level}
                : 32'h0000_0000;
        end
    end
endmodule

/* verilog/pdc_if.sv */
// Link between channel and core side: arbitration plus memory port.
// Assumes both ends on REF_CLK.
`timescale 1ns/1ps
interface pdc_if;
    logic        xfer_req;      // Channel wants a transfer
    logic [2:0]  xfer_prio;     // Its source priority level
    logic        irq_req;       // End-of-block interrupt request
    logic        xfer_grant;    // Core grants the transfer (pulse)
    logic        irq_ack;       // Core acknowledges the interrupt (pulse)
    logic        mem_req;       // Channel access to regfile or memory
    logic        mem_we;
    logic        mem_rf;        // 1 register file, 0 memory
    logic        mem_seg;       // Segment extend select
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [7:0]  mem_rdata;
    logic        mem_ack;       // One cycle per access; waits allowed
    logic        xfer_done;     // Pulse at end of one transfer
    modport chan
    (
        output xfer_req, xfer_prio, irq_req, mem_req, mem_we, mem_rf,
               mem_seg, mem_addr, mem_wdata, xfer_done,
        input  xfer_grant, irq_ack, mem_rdata, mem_ack
    );
    modport core
    (
        input  xfer_req, xfer_prio, irq_req, mem_req, mem_we, mem_rf,
               mem_seg, mem_addr, mem_wdata, xfer_done,
        output xfer_grant, irq_ack, mem_rdata, mem_ack
    );
endinterface

/* verilog/pdc_pkg.sv */
// Package for the peripheral transfer channel and its core-side partner.
// Assumes one core clock, REF_CLK at 100 MHz; all users reference by name.
package pdc_pkg;
    // Control register fields
    localparam int PENDING_BIT   = 5;
    localparam int XFER_MASK_BIT = 4;
    localparam int IRQ_MASK_BIT  = 3;
    localparam int PRIO_MSB      = 2;
    localparam int MODE_BIT      = 0;   // Regfile select / segment select
    // Reset values of channel registers
    localparam logic [7:0] CTRL_RESET  = 8'h00;
    localparam logic [7:0] PTR_RESET   = 8'h00;
    // Register-file bounds for descriptors
    localparam logic [7:0] RF_LAST     = 8'hDF;
    // Block size limits
    localparam int RF_MAX_BLOCK  = 222;
    localparam int MEM_MAX_BLOCK = 65536;
    // Timing in core clock cycles, and number of priority levels
    localparam int SAMPLE_CYCLES = 5;
    localparam int RF_XFER_CYC   = 8;
    localparam int MEM_XFER_CYC  = 16;
    localparam int NUM_LEVELS    = 8;
    // Wishbone register offsets of the host side
    localparam logic [3:0] ADR_CTRL      = 4'h4;
    localparam logic [3:0] ADR_RF        = 4'h8;
    localparam logic [3:0] ADR_STATUS    = 4'hC;
    // Width of the sample divider
    typedef logic [3:0] pdc_cnt_t;
    // Channel sequencer states
    typedef enum logic [2:0]
    {
        PDC_IDLE,
        PDC_RD_DESC,
        PDC_MOVE,
        PDC_WR_DESC,
        PDC_HOLD
    } pdc_state_e;
endpackage
